// ---- core/cba_pkg.sv ----
// Constants, register map and mode encoding for the circular and bit-reversed address unit.
package cba_pkg;

  // ==========================================================================
  // Widths
  localparam int ADDR_W = 16;
  localparam int PADDR_W = 8;

  // ==========================================================================
  // Register offsets (byte addresses on APB)
  localparam logic [7:0] OFF_X_BUFFER_START = 8'h00;
  localparam logic [7:0] OFF_X_BUFFER_END   = 8'h04;
  localparam logic [7:0] OFF_Y_BUFFER_START = 8'h08;
  localparam logic [7:0] OFF_Y_BUFFER_END   = 8'h0C;
  localparam logic [7:0] OFF_CIRC_CONTROL   = 8'h10;
  localparam logic [7:0] OFF_REVERSAL_CTRL  = 8'h14;
  localparam logic [7:0] OFF_DIRECTION      = 8'h18;
  localparam logic [7:0] OFF_STATUS         = 8'h1C;

  // ==========================================================================
  // Field positions
  localparam int X_SEL_LSB   = 0;
  localparam int Y_SEL_LSB   = 4;
  localparam int BR_SEL_LSB  = 8;
  localparam int SEL_W       = 4;
  localparam int X_EN_BIT    = 15;
  localparam int Y_EN_BIT    = 14;
  localparam int BR_EN_BIT   = 15;
  localparam int PIVOT_MSB   = 14;
  localparam int DIR_X_DEC   = 0;
  localparam int DIR_Y_DEC   = 1;
  localparam logic [3:0] SEL_NONE = 4'hF;

  // ==========================================================================
  // Reset values
  localparam logic [15:0] RST_BOUND     = 16'h0000;
  localparam logic [15:0] RST_CIRC_CTRL = 16'h0FFF;
  localparam logic [15:0] RST_REV_CTRL  = 16'h0000;
  localparam logic [1:0]  RST_DIRECTION = 2'h0;

  // ==========================================================================
  // Addressing modes presented by the instruction decoder
  typedef enum logic [1:0] {
    CBA_INDIRECT,
    CBA_POST_MODIFY,
    CBA_PRE_MODIFY,
    CBA_OFFSET
  } cba_mode_t;

endpackage

// ---- core/cba_agu.sv ----
// Circular-buffer and bit-reversed effective address generator with APB registers.
// What this block does
// - One circular buffer in X space and one in Y space, each with own bounds.
// - Non power-of-two buffers wrap in one configured direction only.
// - Power-of-two buffers check both lower and upper bounds.
// - Start and end bounds sit in separate 16-bit registers per space.
// - Buffer length may reach 32K words.
// - Y-space circular addresses are word addresses with bit 0 clear.
// - X wrap needs X select not all ones and X enable set.
// - Y wrap needs Y select not all ones and Y enable set.
// - Wrap triggers only past the bound (above end, below start), so overshoots still wrap.
// - Only pre- and post-modify write the corrected pointer back.
// - Bit reversal only in X space and only for data writes.
// - Pointer and pivot are both bit reversed for the add; the result comes back in normal order.
// - Bit reversal needs select not all ones, enable set, pre/post increment.
// - Reversal enable in bit 15, pivot in bits 14:0 of its control register.
// - Byte accesses or other modes get normal addresses.
// - Bit reversal adds the byte-scaled pivot, ignores the offset, clears bit 0.
// - Bit reversal beats circular correction on the same pointer.
`timescale 1ns/1ps
`default_nettype none

module cba_agu (
  input  wire logic                 core_clk,     // 125 MHz core clock
  input  wire logic                 nrst,         // Asynchronous reset, active low
  input  wire logic                 psel,         // APB select
  input  wire logic                 penable,      // APB access phase
  input  wire logic                 pwrite,       // APB direction
  input  wire logic [7:0]           paddr,        // APB byte address
  input  wire logic [31:0]          pwdata,       // APB write data
  input  wire logic [3:0]           pstrb,        // APB byte strobes
  output logic      [31:0]          prdata,       // APB read data
  output logic                      pready,       // APB ready
  output logic                      pslverr,      // APB error for unmapped address
  input  wire logic                 req_valid,    // Address request strobe
  input  wire logic                 req_space_y,  // Request targets Y space
  input  wire logic                 req_write,    // Request is a data write
  input  wire logic                 req_byte,     // Request is byte sized
  input  wire cba_pkg::cba_mode_t   req_mode,     // Addressing mode
  input  wire logic [3:0]           req_ptr_sel,  // Pointer register number
  input  wire logic [15:0]          req_ptr,      // Pointer register contents
  input  wire logic [15:0]          req_offset,   // Signed modifier or offset
  output logic                      ea_valid,     // Effective address valid
  output logic      [15:0]          ea,           // Effective address
  output logic                      wb_valid,     // Pointer write-back strobe
  output logic      [3:0]           wb_sel,       // Pointer register to update
  output logic      [15:0]          wb_value      // New pointer value
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [15:0] x_start;
    logic [15:0] x_end;
    logic [15:0] y_start;
    logic [15:0] y_end;
    logic [15:0] circ_ctrl;
    logic [15:0] rev_ctrl;
    logic [1:0]  direction;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic        ea_valid;
    logic [15:0] ea;
    logic        wb_valid;
    logic [3:0]  wb_sel;
    logic [15:0] wb_value;
    logic        last_y;
    logic        last_wrap;
    logic        last_rev;
    logic        last_up;
  } cba_state_t;

  cba_state_t st;
  cba_state_t next_st;
  logic [1:0] rst_sync;
  logic       rst_n;

  // ==========================================================================
  // Functions
  function automatic logic [15:0] bit_flip(input logic [15:0] v);
    logic [15:0] r;
    r = '0;
    for (int i = 0; i < 16; i++) begin
      r[i] = v[15 - i];
    end
    return r;
  endfunction

  // Carry propagates from the top bit downward, which walks FFT data in reversed order.
  function automatic logic [15:0] rev_add(input logic [15:0] a, input logic [15:0] b);
    logic [15:0] s;
    s = bit_flip(a) + bit_flip(b);
    return bit_flip(s);
  endfunction

  function automatic logic [15:0] strb_merge(input logic [15:0] old_v, input logic [31:0] d,
                                             input logic [3:0] s);
    logic [15:0] r;
    r = old_v;
    if (s[0]) begin
      r[7:0] = d[7:0];
    end
    if (s[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  function automatic logic is_pow2(input logic [16:0] v);
    return (v != 17'h00000) && ((v & (v - 17'h00001)) == 17'h00000);
  endfunction

  // ==========================================================================
  // Reset release
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // ==========================================================================
  // Address datapath
  logic [3:0]  x_sel;
  logic [3:0]  y_sel;
  logic [3:0]  br_sel;
  logic        x_circ_on;
  logic        y_circ_on;
  logic        circ_on;
  logic        rev_on;
  logic        step_up;
  logic [15:0] raw;
  logic [15:0] b_start;
  logic [15:0] b_end;
  logic [16:0] b_len;
  logic        bidir;
  logic        dec_mode;
  logic        wrap_up;
  logic        wrap_dn;
  logic [15:0] fixed;
  logic [15:0] pivot_bytes;
  logic [15:0] new_ptr;
  logic        modifies;

  always_comb begin
    x_sel  = st.circ_ctrl[cba_pkg::X_SEL_LSB +: cba_pkg::SEL_W];
    y_sel  = st.circ_ctrl[cba_pkg::Y_SEL_LSB +: cba_pkg::SEL_W];
    br_sel = st.circ_ctrl[cba_pkg::BR_SEL_LSB +: cba_pkg::SEL_W];
    modifies = (req_mode == cba_pkg::CBA_PRE_MODIFY) || (req_mode == cba_pkg::CBA_POST_MODIFY);
    step_up = !req_offset[15];
    // Each space owns one buffer; the selects pick which pointer it applies to.
    x_circ_on = !req_space_y && st.circ_ctrl[cba_pkg::X_EN_BIT]
                && (x_sel != cba_pkg::SEL_NONE) && (req_ptr_sel == x_sel);
    y_circ_on = req_space_y && st.circ_ctrl[cba_pkg::Y_EN_BIT]
                && (y_sel != cba_pkg::SEL_NONE) && (req_ptr_sel == y_sel);
    circ_on = (x_circ_on || y_circ_on) && (req_mode != cba_pkg::CBA_INDIRECT);
    rev_on = !req_space_y && req_write && !req_byte && modifies
             && step_up && (req_offset != 16'h0000)
             && st.rev_ctrl[cba_pkg::BR_EN_BIT]
             && (br_sel != cba_pkg::SEL_NONE) && (req_ptr_sel == br_sel);
    raw = req_ptr + req_offset;
    if (req_space_y) begin
      raw[0] = 1'b0;
    end
    b_start = req_space_y ? st.y_start : st.x_start;
    b_end   = req_space_y ? st.y_end : st.x_end;
    // End is the last byte of the buffer, so a 0000..FFFF buffer spans 32K words.
    b_len = {1'b0, b_end} + 17'h00001 - {1'b0, b_start};
    bidir = is_pow2(b_len);
    dec_mode = req_space_y ? st.direction[cba_pkg::DIR_Y_DEC]
                           : st.direction[cba_pkg::DIR_X_DEC];
    wrap_up = step_up && (bidir || !dec_mode) && (raw > b_end);
    wrap_dn = !step_up && (bidir || dec_mode) && (raw < b_start);
    fixed = raw;
    if (wrap_up) begin
      fixed = raw - b_len[15:0];
    end else if (wrap_dn) begin
      fixed = raw + b_len[15:0];
    end
    pivot_bytes = {st.rev_ctrl[cba_pkg::PIVOT_MSB:0], 1'b0};
    if (rev_on) begin
      new_ptr = rev_add(req_ptr, pivot_bytes);
      new_ptr[0] = 1'b0;
    end else if (circ_on) begin
      new_ptr = fixed;
      if (req_space_y) begin
        new_ptr[0] = 1'b0;
      end
    end else begin
      new_ptr = raw;
    end
  end

  // ==========================================================================
  // Next state
  logic       setup;
  logic       access;
  logic       mapped;
  logic [7:0] a;

  always_comb begin
    next_st = st;
    a = paddr;
    setup = psel && !penable;
    access = psel && penable && st.pready;
    mapped = (a == cba_pkg::OFF_X_BUFFER_START) || (a == cba_pkg::OFF_X_BUFFER_END)
             || (a == cba_pkg::OFF_Y_BUFFER_START) || (a == cba_pkg::OFF_Y_BUFFER_END)
             || (a == cba_pkg::OFF_CIRC_CONTROL) || (a == cba_pkg::OFF_REVERSAL_CTRL)
             || (a == cba_pkg::OFF_DIRECTION) || (a == cba_pkg::OFF_STATUS);
    // Ready is raised one cycle after setup so it can come straight from a flop.
    next_st.pready = setup;
    next_st.pslverr = setup && !mapped;
    if (setup) begin
      case (a)
        cba_pkg::OFF_X_BUFFER_START: next_st.prdata = {16'h0000, st.x_start};
        cba_pkg::OFF_X_BUFFER_END:   next_st.prdata = {16'h0000, st.x_end};
        cba_pkg::OFF_Y_BUFFER_START: next_st.prdata = {16'h0000, st.y_start};
        cba_pkg::OFF_Y_BUFFER_END:   next_st.prdata = {16'h0000, st.y_end};
        cba_pkg::OFF_CIRC_CONTROL:   next_st.prdata = {16'h0000, st.circ_ctrl};
        cba_pkg::OFF_REVERSAL_CTRL:  next_st.prdata = {16'h0000, st.rev_ctrl};
        cba_pkg::OFF_DIRECTION:      next_st.prdata = {30'h00000000, st.direction};
        cba_pkg::OFF_STATUS:         next_st.prdata = {12'h000, st.last_up, st.last_rev,
                                                       st.last_wrap, st.last_y, st.ea};
        default:                     next_st.prdata = 32'h00000000;
      endcase
    end
    if (access && pwrite && !st.pslverr) begin
      case (a)
        cba_pkg::OFF_X_BUFFER_START: next_st.x_start = strb_merge(st.x_start, pwdata, pstrb);
        cba_pkg::OFF_X_BUFFER_END:   next_st.x_end = strb_merge(st.x_end, pwdata, pstrb);
        cba_pkg::OFF_Y_BUFFER_START: next_st.y_start = strb_merge(st.y_start, pwdata, pstrb);
        cba_pkg::OFF_Y_BUFFER_END:   next_st.y_end = strb_merge(st.y_end, pwdata, pstrb);
        cba_pkg::OFF_CIRC_CONTROL:   next_st.circ_ctrl = strb_merge(st.circ_ctrl, pwdata, pstrb);
        cba_pkg::OFF_REVERSAL_CTRL:  next_st.rev_ctrl = strb_merge(st.rev_ctrl, pwdata, pstrb);
        cba_pkg::OFF_DIRECTION: begin
          if (pstrb[0]) begin
            next_st.direction = pwdata[1:0];
          end
        end
        default: begin
        end
      endcase
    end
    next_st.ea_valid = req_valid;
    next_st.wb_valid = req_valid && modifies;
    if (req_valid) begin
      case (req_mode)
        cba_pkg::CBA_INDIRECT:    next_st.ea = req_ptr;
        cba_pkg::CBA_POST_MODIFY: next_st.ea = req_ptr;
        cba_pkg::CBA_PRE_MODIFY:  next_st.ea = new_ptr;
        cba_pkg::CBA_OFFSET:      next_st.ea = new_ptr;
        default:                  next_st.ea = req_ptr;
      endcase
      if (req_space_y && circ_on) begin
        next_st.ea[0] = 1'b0;
      end
      next_st.wb_sel = req_ptr_sel;
      next_st.wb_value = new_ptr;
      next_st.last_y = req_space_y;
      next_st.last_rev = rev_on;
      next_st.last_wrap = circ_on && !rev_on && (wrap_up || wrap_dn);
      next_st.last_up = step_up;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.x_start <= cba_pkg::RST_BOUND;
      st.x_end <= cba_pkg::RST_BOUND;
      st.y_start <= cba_pkg::RST_BOUND;
      st.y_end <= cba_pkg::RST_BOUND;
      st.circ_ctrl <= cba_pkg::RST_CIRC_CTRL;
      st.rev_ctrl <= cba_pkg::RST_REV_CTRL;
      st.direction <= cba_pkg::RST_DIRECTION;
    end else begin
      st <= next_st;
    end
  end

  assign prdata   = st.prdata;
  assign pready   = st.pready;
  assign pslverr  = st.pslverr;
  assign ea_valid = st.ea_valid;
  assign ea       = st.ea;
  assign wb_valid = st.wb_valid;
  assign wb_sel   = st.wb_sel;
  assign wb_value = st.wb_value;

  // ==========================================================================
  // Assertions
  property p_offset_no_writeback;
    @(posedge core_clk) disable iff (!rst_n)
    req_valid && (req_mode == cba_pkg::CBA_OFFSET) |=> ea_valid && !wb_valid;
  endproperty
  a_offset_no_writeback: assert property (p_offset_no_writeback)
    else $error("Offset mode wrote the pointer back.");

  property p_y_word;
    @(posedge core_clk) disable iff (!rst_n)
    req_valid && y_circ_on && (req_mode != cba_pkg::CBA_INDIRECT) |=> !ea[0] && !wb_value[0];
  endproperty
  a_y_word: assert property (p_y_word)
    else $error("Y circular address has bit 0 set.");

  property p_rev_lsb_clear;
    @(posedge core_clk) disable iff (!rst_n)
    req_valid && rev_on |=> wb_valid && !wb_value[0] && st.last_rev;
  endproperty
  a_rev_lsb_clear: assert property (p_rev_lsb_clear)
    else $error("Bit-reversed pointer has bit 0 set.");

  property p_x_disabled;
    @(posedge core_clk) disable iff (!rst_n)
    req_valid && !req_space_y && ((x_sel == cba_pkg::SEL_NONE)
      || !st.circ_ctrl[cba_pkg::X_EN_BIT]) |=> !st.last_wrap;
  endproperty
  a_x_disabled: assert property (p_x_disabled)
    else $error("X wrap while X circular mode is off.");

  property p_y_disabled;
    @(posedge core_clk) disable iff (!rst_n)
    req_valid && req_space_y && ((y_sel == cba_pkg::SEL_NONE)
      || !st.circ_ctrl[cba_pkg::Y_EN_BIT]) |=> !st.last_wrap;
  endproperty
  a_y_disabled: assert property (p_y_disabled)
    else $error("Y wrap while Y circular mode is off.");

  property p_rev_only_x_write;
    @(posedge core_clk) disable iff (!rst_n)
    req_valid && (req_space_y || !req_write || req_byte) |=> !st.last_rev;
  endproperty
  a_rev_only_x_write: assert property (p_rev_only_x_write)
    else $error("Bit reversal on a read, byte or Y access.");

  property p_rev_wins;
    @(posedge core_clk) disable iff (!rst_n)
    req_valid && rev_on && x_circ_on |=> st.last_rev && !st.last_wrap
      && (wb_value == ($past(rev_add(req_ptr, pivot_bytes)) & 16'hFFFE));
  endproperty
  a_rev_wins: assert property (p_rev_wins)
    else $error("Circular correction overrode bit reversal.");

  property p_wrap_up_len;
    @(posedge core_clk) disable iff (!rst_n)
    req_valid && circ_on && !rev_on && wrap_up && modifies
      |=> wb_value == $past(raw) - $past(b_len[15:0]);
  endproperty
  a_wrap_up_len: assert property (p_wrap_up_len)
    else $error("Upward wrap did not subtract the length.");

  property p_wrap_dn_len;
    @(posedge core_clk) disable iff (!rst_n)
    req_valid && circ_on && !rev_on && wrap_dn && modifies
      |=> wb_value == $past(raw) + $past(b_len[15:0]) && st.last_wrap;
  endproperty
  a_wrap_dn_len: assert property (p_wrap_dn_len)
    else $error("Downward wrap did not add the length.");

  property p_bound_write;
    @(posedge core_clk) disable iff (!rst_n)
    psel && penable && pready && pwrite && !pslverr && (pstrb[1:0] == 2'h3)
      && (paddr == cba_pkg::OFF_X_BUFFER_START) |=> st.x_start == $past(pwdata[15:0]);
  endproperty
  a_bound_write: assert property (p_bound_write)
    else $error("X start bound did not take the written value.");

  property p_apb_ready;
    @(posedge core_clk) disable iff (!rst_n)
    psel && !penable |=> pready ##1 !pready;
  endproperty
  a_apb_ready: assert property (p_apb_ready)
    else $error("APB ready not given one cycle after setup.");

endmodule

`default_nettype wire

// ---- verif/cba_cpu_model.sv ----
// CPU-side partner: pointer register file and address request driver.
`timescale 1ns/1ps
`default_nettype none

module cba_cpu_model (
  input  wire logic          core_clk,    // Core clock
  output logic               req_valid,   // Request strobe
  output logic               req_space_y, // Y space
  output logic               req_write,   // Data write
  output logic               req_byte,    // Byte sized
  output cba_pkg::cba_mode_t req_mode,    // Addressing mode
  output logic [3:0]         req_ptr_sel, // Pointer number
  output logic [15:0]        req_ptr,     // Pointer contents
  output logic [15:0]        req_offset,  // Modifier or offset
  input  wire logic          wb_valid,    // Write-back strobe
  input  wire logic [3:0]    wb_sel,      // Pointer to update
  input  wire logic [15:0]   wb_value     // New pointer value
);
  // ==========================================================================
  // Pointer file
  logic [15:0] ptrs [16];

  initial begin
    {req_valid, req_space_y, req_write, req_byte} = 4'h0;
    req_mode = cba_pkg::CBA_INDIRECT;
    {req_ptr_sel, req_ptr, req_offset} = 36'h0;
  end

  always @(posedge core_clk) begin
    if (wb_valid)
      ptrs[wb_sel] <= wb_value;
  end

  task automatic set_ptr(input logic [3:0] s, input logic [15:0] v);
    ptrs[s] = v;
  endtask

  // ==========================================================================
  // Request driver
  // Callers keep pointers 14 and 15 for the frame and the stack, never circular.
  task automatic issue(input logic [2:0] ywb, input cba_pkg::cba_mode_t m,
                       input logic [3:0] s, input logic [15:0] off);
    @(posedge core_clk);
    req_valid <= 1'b1;
    {req_space_y, req_write, req_byte} <= ywb;
    req_mode <= m;
    {req_ptr_sel, req_ptr, req_offset} <= {s, ptrs[s], off};
    @(posedge core_clk);
    req_valid <= 1'b0;
    // Stale pointer and offset fields are scrambled so that nothing leans on an unqualified value.
    {req_ptr, req_offset} <= ~{req_ptr, req_offset};
  endtask
endmodule

`default_nettype wire

// ---- verif/cba_agu_tb.sv ----
// Self-checking testbench for the circular and bit-reversed address unit.
`timescale 1ns/1ps
`default_nettype none

module cba_agu_tb;
  localparam cba_pkg::cba_mode_t POST = cba_pkg::CBA_POST_MODIFY;
  localparam cba_pkg::cba_mode_t PRE  = cba_pkg::CBA_PRE_MODIFY;
  localparam cba_pkg::cba_mode_t OFS  = cba_pkg::CBA_OFFSET;
  localparam logic [7:0] CTRL = cba_pkg::OFF_CIRC_CONTROL;
  localparam logic [7:0] REV  = cba_pkg::OFF_REVERSAL_CTRL;

  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready, pslverr, req_valid, req_space_y, req_write, req_byte;
  logic ea_valid, wb_valid;
  cba_pkg::cba_mode_t req_mode;
  logic [3:0] req_ptr_sel, wb_sel;
  logic [15:0] req_ptr, req_offset, ea, wb_value;
  int n_errors = 0;
  int checks_done = 0;

  always #4 core_clk = ~core_clk;

  cba_agu dut_u (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .req_valid(req_valid), .req_space_y(req_space_y),
    .req_write(req_write), .req_byte(req_byte), .req_mode(req_mode),
    .req_ptr_sel(req_ptr_sel), .req_ptr(req_ptr), .req_offset(req_offset),
    .ea_valid(ea_valid), .ea(ea), .wb_valid(wb_valid), .wb_sel(wb_sel), .wb_value(wb_value));

  cba_cpu_model pm_u (.core_clk(core_clk), .req_valid(req_valid), .req_space_y(req_space_y),
    .req_write(req_write), .req_byte(req_byte), .req_mode(req_mode),
    .req_ptr_sel(req_ptr_sel), .req_ptr(req_ptr), .req_offset(req_offset),
    .wb_valid(wb_valid), .wb_sel(wb_sel), .wb_value(wb_value));

  // ==========================================================================
  // Tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge core_clk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge core_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait that never sees ready.
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    {r, e} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk("prdata", x, r);
    chk("pslverr", {31'h0, xe}, {31'h0, e});
  endtask

  // Loads the pointer, issues one request and checks the answer one cycle later.
  task automatic rq(input logic [2:0] ywb, input cba_pkg::cba_mode_t m, input logic [3:0] s,
                    input logic [15:0] p, input logic [15:0] off, input logic [15:0] xea,
                    input logic xwb, input logic [15:0] xv);
    pm_u.set_ptr(s, p);
    pm_u.issue(ywb, m, s, off);
    #1;
    chk("ea_valid", 32'h1, {31'h0, ea_valid});
    chk("ea", {16'h0, xea}, {16'h0, ea});
    chk("wb_valid", {31'h0, xwb}, {31'h0, wb_valid});
    chk("wb_sel", {28'h0, s}, {28'h0, wb_sel});
    if (xwb)
      chk("wb_value", {16'h0, xv}, {16'h0, wb_value});
  endtask

  task automatic summarize();
    $display("Checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ==========================================================================
  // Tests
  initial begin
    #100000;
    n_errors++;
    summarize();
  end

  initial begin
    repeat (3) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(CTRL, 32'h0FFF, 1'b0);
    rd(REV, 32'h0, 1'b0);
    rd(8'h20, 32'h0, 1'b1);
    wr(cba_pkg::OFF_X_BUFFER_START, 32'h1000);
    wr(cba_pkg::OFF_X_BUFFER_END, 32'h101F);
    wr(cba_pkg::OFF_Y_BUFFER_START, 32'h2000);
    wr(cba_pkg::OFF_Y_BUFFER_END, 32'h2017);
    rd(cba_pkg::OFF_X_BUFFER_END, 32'h101F, 1'b0);
    rd(cba_pkg::OFF_Y_BUFFER_START, 32'h2000, 1'b0);
    wr(CTRL, 32'h4542);
    rq(3'h0, POST, 4'h2, 16'h101E, 16'h0002, 16'h101E, 1'b1, 16'h1020);
    wr(CTRL, 32'hC542);
    rq(3'h0, POST, 4'h2, 16'h101E, 16'h0002, 16'h101E, 1'b1, 16'h1000);
    rq(3'h0, PRE, 4'h2, 16'h101C, 16'h0006, 16'h1002, 1'b1, 16'h1002);
    rq(3'h0, PRE, 4'h2, 16'h1000, 16'hFFFE, 16'h101E, 1'b1, 16'h101E);
    rq(3'h0, OFS, 4'h2, 16'h101E, 16'h0004, 16'h1002, 1'b0, 16'h0);
    rq(3'h0, cba_pkg::CBA_INDIRECT, 4'h2, 16'h101E, 16'h0004, 16'h101E, 1'b0, 16'h0);
    rq(3'h0, POST, 4'h3, 16'h101E, 16'h0002, 16'h101E, 1'b1, 16'h1020);
    rq(3'h4, POST, 4'h4, 16'h2016, 16'h0002, 16'h2016, 1'b1, 16'h2000);
    rq(3'h4, PRE, 4'h4, 16'h2000, 16'hFFFE, 16'h1FFE, 1'b1, 16'h1FFE);
    rq(3'h4, PRE, 4'h4, 16'h2003, 16'h0002, 16'h2004, 1'b1, 16'h2004);
    wr(cba_pkg::OFF_DIRECTION, 32'h2);
    rq(3'h4, PRE, 4'h4, 16'h2000, 16'hFFFE, 16'h2016, 1'b1, 16'h2016);
    rq(3'h4, PRE, 4'h4, 16'h2016, 16'h0002, 16'h2018, 1'b1, 16'h2018);
    // The bit-reversed buffer sits at 4000, aligned to its length.
    // A register read separates the control write from the first pointer use.
    wr(REV, 32'h8008);
    rd(REV, 32'h8008, 1'b0);
    rq(3'h2, POST, 4'h5, 16'h4000, 16'h0002, 16'h4000, 1'b1, 16'h4010);
    rq(3'h2, PRE, 4'h5, 16'h4010, 16'h0002, 16'h4008, 1'b1, 16'h4008);
    rq(3'h0, PRE, 4'h5, 16'h4010, 16'h0002, 16'h4012, 1'b1, 16'h4012);
    rq(3'h6, PRE, 4'h5, 16'h4010, 16'h0002, 16'h4012, 1'b1, 16'h4012);
    rq(3'h3, PRE, 4'h5, 16'h4010, 16'h0001, 16'h4011, 1'b1, 16'h4011);
    rq(3'h2, OFS, 4'h5, 16'h4010, 16'h0002, 16'h4012, 1'b0, 16'h0);
    wr(CTRL, 32'hC545);
    rq(3'h2, PRE, 4'h5, 16'h4010, 16'h0002, 16'h4008, 1'b1, 16'h4008);
    wr(REV, 32'h0008);
    rq(3'h2, PRE, 4'h5, 16'h4010, 16'h0002, 16'h3FF2, 1'b1, 16'h3FF2);
    rd(cba_pkg::OFF_STATUS, 32'h000A3FF2, 1'b0);
    wr(CTRL, 32'h8545);
    rq(3'h4, PRE, 4'h4, 16'h2000, 16'hFFFE, 16'h1FFE, 1'b1, 16'h1FFE);
    summarize();
  end
endmodule

`default_nettype wire
